// ==== hdl/pid_post_pkg.sv ====
package pid_post_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned STEP_TIME_MS    = 10;
  localparam int unsigned STEP_CYCLES_DEF =
    STEP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned DWELL_UNIT_MS   = 100;
  localparam int unsigned DWELL_STEPS     = DWELL_UNIT_MS / STEP_TIME_MS;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_OFFSET      = 12'h004;
  localparam logic [11:0] ADDR_FILTER      = 12'h008;
  localparam logic [11:0] ADDR_GAIN        = 12'h00c;
  localparam logic [11:0] ADDR_LOW_LEVEL   = 12'h010;
  localparam logic [11:0] ADDR_LOW_TIME    = 12'h014;
  localparam logic [11:0] ADDR_HIGH_LEVEL  = 12'h018;
  localparam logic [11:0] ADDR_HIGH_TIME   = 12'h01c;
  localparam logic [11:0] ADDR_SLEEP_LEVEL = 12'h020;
  localparam logic [11:0] ADDR_SLEEP_DELAY = 12'h024;
  localparam logic [11:0] ADDR_STATUS      = 12'h028;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h02c;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h030;
  localparam logic [11:0] ADDR_OUTPUT      = 12'h034;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_POL_BIT  = 3;
  localparam int unsigned CTRL_REV_BIT  = 4;
  localparam int unsigned CTRL_LOSS_LSB = 5;
  localparam int unsigned CTRL_STOP_LSB = 8;
  localparam int unsigned CTRL_FCLR_BIT = 10;

  // Reset values and ranges
  localparam logic signed [15:0] OFFSET_RST  = 16'sh0000;
  localparam logic signed [15:0] OFFSET_MAX  = 16'sh03e8;
  localparam logic [10:0]        FILTER_RST  = 11'h000;
  localparam logic [10:0]        FILTER_MAX  = 11'h3e8;
  localparam logic [11:0]        GAIN_RST    = 12'h064;
  localparam logic [11:0]        GAIN_MAX    = 12'h9c4;
  localparam logic [31:0]        GAIN_UNITY  = 32'h0000_0064;
  localparam logic [6:0]         LOW_LVL_RST = 7'h00;
  localparam logic [6:0]         HI_LVL_RST  = 7'h64;
  localparam logic [6:0]         LEVEL_MAX   = 7'h64;
  localparam logic [7:0]         DET_TIME_RST = 8'h0a;
  localparam logic [11:0]        SLEEP_LVL_RST = 12'h000;
  localparam logic [11:0]        SLEEP_LVL_MAX = 12'hfa0;
  localparam logic [7:0]         SLEEP_DLY_RST = 8'h00;
  localparam logic [2:0]         MODE_MAX    = 3'h4;
  localparam logic [2:0]         LOSS_MAX    = 3'h5;
  localparam logic [15:0]        FULL_SCALE  = 16'h03e8;
  localparam logic [15:0]        LEVEL_SCALE = 16'h000a;
  localparam logic [15:0]        MAX_FREQ_DEF = 16'h0258;

  // Modes and loss classes
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_TRIM_1  = 3'h3;
  localparam logic [2:0] MODE_TRIM_2  = 3'h4;
  localparam logic [2:0] LOSS_ALARM   = 3'h1;
  localparam logic [2:0] LOSS_FAULT   = 3'h2;
  localparam logic [2:0] LOSS_ALWAYS  = 3'h3;

  // Interrupt bits
  localparam int unsigned IRQ_LOW   = 0;
  localparam int unsigned IRQ_HIGH  = 1;
  localparam int unsigned IRQ_FAULT = 2;
  localparam int unsigned IRQ_SLEEP = 3;
  localparam int unsigned IRQ_WAKE  = 4;
  localparam int unsigned IRQ_W     = 5;

  // Filter fraction bits
  localparam int unsigned FILT_FRAC = 8;

  typedef enum logic [1:0] {
    SLP_AWAKE  = 2'b00,
    SLP_ASLEEP = 2'b01
  } sleep_state_t;

endpackage : pid_post_pkg

// ==== hdl/pid_output_feedback_sleep.sv ====
// Behaviour
// - Add signed offset to controller output
// - First-order lag filter, zero time bypasses
// - Polarity select inverts controller action
// - Multiply output by programmable gain
// - Negative output clamps and stops, or reverses
// - Trim modes ignore reverse, no clamp
// - Low feedback dwell detection
// - High feedback dwell detection
// - Loss mode 0: flags only, keep running
// - Loss mode 1: flags plus alarm output
// - Loss mode 2: latched fault, stop motor
// - Modes 3-5 detect despite disable input
// - Sleep below level, wake above, both delayed
// - Sleep supervision always active
// - Sleep stops with selected stop method
// - Programmable sleep delay, default zero
// - Trim modes add output to reference
//
// Implementation choices: the address map and the APB slave port.
module pid_output_feedback_sleep
  import pid_post_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata_q,
  output logic                    pready_q,
  output logic                    pslverr_q,
  // Process inputs
  input  wire logic signed [15:0] pid_core_in,
  input  wire logic        [15:0] freq_ref_in,
  input  wire logic        [15:0] feedback_in,
  input  wire logic        [15:0] max_freq_in,
  input  wire logic               pid_disable_in,
  input  wire logic               run_cmd_in,
  // Drive output stage
  output logic             [15:0] freq_cmd_q,
  output logic                    dir_reverse_q,
  output logic                    run_enable_q,
  output logic              [1:0] stop_method_q,
  // Supervision outputs
  output logic                    fb_low_flag_q,
  output logic                    fb_high_flag_q,
  output logic                    alarm_q,
  output logic                    fault_q,
  output logic                    sleep_q,
  output logic                    irq_q
);

  // Saturate to the symmetric range -32767 to +32767
  function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      return 16'sh7fff;
    end else if (v < -32'sd32767) begin
      return -16'sh7fff;
    end
    return v[15:0];
  endfunction : sat16

  // Percent of max frequency (0.1 %) to 0.1 Hz
  function automatic logic [15:0] to_dhz(input logic [15:0] pct,
                                         input logic [15:0] fmax);
    logic [31:0] p;
    p = 32'(pct) * 32'(fmax) / 32'(FULL_SCALE);
    return p[15:0];
  endfunction : to_dhz

  // Settings
  logic        [2:0]  function_mode_q;
  logic               output_polarity_select_q;
  logic               reverse_select_q;
  logic        [2:0]  loss_action_select_q;
  logic        [1:0]  stop_method_setting_q;
  logic signed [15:0] output_offset_setting_q;
  logic        [10:0] output_filter_time_constant_q;
  logic        [11:0] output_gain_setting_q;
  logic        [6:0]  low_detection_level_q;
  logic        [7:0]  low_detection_time_q;
  logic        [6:0]  high_detection_level_q;
  logic        [7:0]  high_detection_time_q;
  logic        [11:0] sleep_level_q;
  logic        [7:0]  sleep_delay_q;
  logic        [IRQ_W-1:0] irq_status_q;
  logic        [IRQ_W-1:0] irq_mask_q;

  // Internal state
  logic        [31:0] step_cnt_q;
  logic        [3:0]  dwell_cnt_q;
  logic               step_tick;
  logic               dwell_tick;
  logic signed [31:0] filt_q;
  logic        [7:0]  det_cnt_q [2];
  logic        [1:0]  det_q;
  logic        [1:0]  fault_kind_q;
  logic        [7:0]  sleep_cnt_q;
  sleep_state_t       sleep_state_q;

  // Bus decode
  logic wr_en;
  logic setup;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite;

  // Step tick every 10 ms and dwell tick every 0.1 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_q  <= 32'h0;
      dwell_cnt_q <= 4'h0;
    end else if (step_tick) begin
      step_cnt_q  <= 32'h0;
      dwell_cnt_q <= dwell_tick ? 4'h0 : dwell_cnt_q + 4'h1;
    end else begin
      step_cnt_q <= step_cnt_q + 32'h1;
    end
  end
  assign step_tick  = (step_cnt_q == STEP_CYCLES - 1);
  assign dwell_tick = step_tick && (dwell_cnt_q == 4'(DWELL_STEPS - 1));

  // Controller output chain, combinational
  logic               pid_active;
  logic signed [31:0] pol_v;
  logic signed [15:0] offs_v;
  logic signed [15:0] filt_v;
  logic signed [15:0] gain_v;
  logic signed [31:0] trim_v;
  logic        [15:0] cmd_d;
  logic               rev_d;
  logic               clamp_stop;
  logic        [15:0] sleep_src;
  logic        [1:0]  det_cond;
  logic               det_enable;
  logic        [2:0]  loss_class;

  always_comb begin
    pid_active = (function_mode_q != MODE_OFF) && !pid_disable_in;
    // Reverse acting swaps the sign of the core output
    pol_v  = output_polarity_select_q ? -32'(pid_core_in)
                                      : 32'(pid_core_in);
    offs_v = sat16(pol_v + 32'(output_offset_setting_q));
    filt_v = (output_filter_time_constant_q == 11'h0)
             ? offs_v : sat16(filt_q >>> FILT_FRAC);
    gain_v = sat16(32'(filt_v) * $signed(32'(output_gain_setting_q))
                   / $signed(GAIN_UNITY));
    trim_v = 32'(freq_ref_in) + 32'(gain_v);
    cmd_d      = freq_ref_in;
    rev_d      = 1'b0;
    clamp_stop = 1'b0;
    if (pid_active && (function_mode_q == MODE_TRIM_1 ||
                       function_mode_q == MODE_TRIM_2)) begin
      // Trim: add to reference, sign gives direction
      if (trim_v < 0) begin
        rev_d = 1'b1;
        cmd_d = 16'(-sat16(trim_v));
      end else begin
        cmd_d = 16'(sat16(trim_v));
      end
    end else if (pid_active) begin
      if (gain_v >= 0) begin
        cmd_d = 16'(gain_v);
      end else if (reverse_select_q) begin
        rev_d = 1'b1;
        cmd_d = 16'(-gain_v);
      end else begin
        cmd_d      = 16'h0;
        clamp_stop = 1'b1;
      end
    end
    // Sleep watches PID output, or the reference without PID
    sleep_src = to_dhz(cmd_d, max_freq_in);
    // Levels are whole percent, feedback is 0.1 %
    det_cond[0] = feedback_in <
                  16'(low_detection_level_q) * LEVEL_SCALE;
    det_cond[1] = feedback_in >
                  16'(high_detection_level_q) * LEVEL_SCALE;
    det_enable = (function_mode_q != MODE_OFF) &&
                 (!pid_disable_in ||
                  loss_action_select_q >= LOSS_ALWAYS);
    loss_class = (loss_action_select_q >= LOSS_ALWAYS)
                 ? loss_action_select_q - LOSS_ALWAYS
                 : loss_action_select_q;
  end

  // Lag filter state, stepped every 10 ms: y += (x - y) / T
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 32'sh0;
    end else if (output_filter_time_constant_q == 11'h0) begin
      filt_q <= 32'(offs_v) <<< FILT_FRAC;
    end else if (step_tick) begin
      filt_q <= filt_q + ((32'(offs_v) <<< FILT_FRAC) - filt_q)
                / $signed(32'(output_filter_time_constant_q));
    end
  end

  // Feedback dwell timers, counted in 0.1 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_cnt_q[0] <= 8'h0;
      det_cnt_q[1] <= 8'h0;
      det_q        <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!det_enable || !det_cond[i]) begin
          det_cnt_q[i] <= 8'h0;
          det_q[i]     <= 1'b0;
        end else if (det_cnt_q[i] >=
                     (i == 0 ? low_detection_time_q
                             : high_detection_time_q)) begin
          det_q[i] <= 1'b1;
        end else if (dwell_tick) begin
          det_cnt_q[i] <= det_cnt_q[i] + 8'h1;
        end
      end
    end
  end

  // Fault latch, new detection wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_kind_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (det_q[i] && loss_class == LOSS_FAULT) begin
          fault_kind_q[i] <= 1'b1;
        end else if (wr_en && paddr == ADDR_CTRL &&
                     pwdata[CTRL_FCLR_BIT]) begin
          fault_kind_q[i] <= 1'b0;
        end
      end
    end
  end

  // Sleep state machine with shared delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_state_q <= SLP_AWAKE;
      sleep_cnt_q   <= 8'h0;
    end else begin
      case (sleep_state_q)
        SLP_AWAKE: begin
          if (sleep_src >= 16'(sleep_level_q)) begin
            sleep_cnt_q <= 8'h0;
          end else if (sleep_cnt_q >= sleep_delay_q) begin
            sleep_state_q <= SLP_ASLEEP;
            sleep_cnt_q   <= 8'h0;
          end else if (dwell_tick) begin
            sleep_cnt_q <= sleep_cnt_q + 8'h1;
          end
        end
        SLP_ASLEEP: begin
          if (sleep_src <= 16'(sleep_level_q)) begin
            sleep_cnt_q <= 8'h0;
          end else if (sleep_cnt_q >= sleep_delay_q) begin
            sleep_state_q <= SLP_AWAKE;
            sleep_cnt_q   <= 8'h0;
          end else if (dwell_tick) begin
            sleep_cnt_q <= sleep_cnt_q + 8'h1;
          end
        end
        default: begin
          sleep_state_q <= SLP_AWAKE;
          sleep_cnt_q   <= 8'h0;
        end
      endcase
    end
  end

  // Drive and supervision outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd_q     <= 16'h0;
      dir_reverse_q  <= 1'b0;
      run_enable_q   <= 1'b0;
      stop_method_q  <= 2'h0;
      fb_low_flag_q  <= 1'b0;
      fb_high_flag_q <= 1'b0;
      alarm_q        <= 1'b0;
      fault_q        <= 1'b0;
      sleep_q        <= 1'b0;
    end else begin
      freq_cmd_q    <= cmd_d;
      dir_reverse_q <= rev_d;
      // Sleep, fault and clamp all stop the drive
      run_enable_q  <= run_cmd_in && !clamp_stop &&
                       (sleep_state_q == SLP_AWAKE) &&
                       (fault_kind_q == 2'b00);
      stop_method_q <= stop_method_setting_q;
      fb_low_flag_q  <= det_q[0] && loss_class != LOSS_FAULT;
      fb_high_flag_q <= det_q[1] && loss_class != LOSS_FAULT;
      alarm_q <= (|det_q) && loss_class == LOSS_ALARM;
      fault_q <= |fault_kind_q;
      sleep_q <= sleep_state_q == SLP_ASLEEP;
    end
  end

  // Settings registers; out-of-range writes saturate, except mode and loss selects, which are refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      function_mode_q               <= MODE_OFF;
      output_polarity_select_q      <= 1'b0;
      reverse_select_q              <= 1'b0;
      loss_action_select_q          <= 3'h0;
      stop_method_setting_q         <= 2'h0;
      output_offset_setting_q       <= OFFSET_RST;
      output_filter_time_constant_q <= FILTER_RST;
      output_gain_setting_q         <= GAIN_RST;
      low_detection_level_q         <= LOW_LVL_RST;
      low_detection_time_q          <= DET_TIME_RST;
      high_detection_level_q        <= HI_LVL_RST;
      high_detection_time_q         <= DET_TIME_RST;
      sleep_level_q                 <= SLEEP_LVL_RST;
      sleep_delay_q                 <= SLEEP_DLY_RST;
      irq_mask_q                    <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          if (pwdata[CTRL_MODE_LSB +: 3] <= MODE_MAX) begin
            function_mode_q <= pwdata[CTRL_MODE_LSB +: 3];
          end
          output_polarity_select_q <= pwdata[CTRL_POL_BIT];
          reverse_select_q         <= pwdata[CTRL_REV_BIT];
          // Values above five are refused
          if (pwdata[CTRL_LOSS_LSB +: 3] <= LOSS_MAX) begin
            loss_action_select_q <= pwdata[CTRL_LOSS_LSB +: 3];
          end
          stop_method_setting_q <= pwdata[CTRL_STOP_LSB +: 2];
        end
        ADDR_OFFSET: begin
          if ($signed(pwdata[15:0]) > OFFSET_MAX) begin
            output_offset_setting_q <= OFFSET_MAX;
          end else if ($signed(pwdata[15:0]) < -OFFSET_MAX) begin
            output_offset_setting_q <= -OFFSET_MAX;
          end else begin
            output_offset_setting_q <= pwdata[15:0];
          end
        end
        ADDR_FILTER: output_filter_time_constant_q <=
          (pwdata[10:0] > FILTER_MAX) ? FILTER_MAX : pwdata[10:0];
        ADDR_GAIN: output_gain_setting_q <=
          (pwdata[11:0] > GAIN_MAX) ? GAIN_MAX : pwdata[11:0];
        ADDR_LOW_LEVEL: low_detection_level_q <=
          (pwdata[6:0] > LEVEL_MAX) ? LEVEL_MAX : pwdata[6:0];
        ADDR_LOW_TIME: low_detection_time_q <= pwdata[7:0];
        ADDR_HIGH_LEVEL: high_detection_level_q <=
          (pwdata[6:0] > LEVEL_MAX) ? LEVEL_MAX : pwdata[6:0];
        ADDR_HIGH_TIME: high_detection_time_q <= pwdata[7:0];
        ADDR_SLEEP_LEVEL: sleep_level_q <=
          (pwdata[11:0] > SLEEP_LVL_MAX) ? SLEEP_LVL_MAX : pwdata[11:0];
        ADDR_SLEEP_DELAY: sleep_delay_q <= pwdata[7:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Interrupt events: rising detections, fault, sleep entry and exit
  logic [IRQ_W-1:0] irq_ev;
  logic [1:0]       det_prev_q;
  logic             fault_prev_q;
  logic             sleep_prev_q;
  assign irq_ev[IRQ_LOW]   = det_q[0] && !det_prev_q[0];
  assign irq_ev[IRQ_HIGH]  = det_q[1] && !det_prev_q[1];
  assign irq_ev[IRQ_FAULT] = (|fault_kind_q) && !fault_prev_q;
  assign irq_ev[IRQ_SLEEP] = (sleep_state_q == SLP_ASLEEP) && !sleep_prev_q;
  assign irq_ev[IRQ_WAKE]  = (sleep_state_q == SLP_AWAKE) && sleep_prev_q;

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_prev_q   <= 2'b00;
      fault_prev_q <= 1'b0;
      sleep_prev_q <= 1'b0;
      irq_status_q <= '0;
      irq_q        <= 1'b0;
    end else begin
      det_prev_q   <= det_q;
      fault_prev_q <= |fault_kind_q;
      sleep_prev_q <= sleep_state_q == SLP_ASLEEP;
      if (wr_en && paddr == ADDR_IRQ_STATUS) begin
        irq_status_q <= (irq_status_q & ~pwdata[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_status_q <= irq_status_q | irq_ev;
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // APB: data captured in setup, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= 1'b0;
      if (setup) begin
        prdata_q <= 32'h0;
        case (paddr)
          ADDR_CTRL: prdata_q <= 32'({stop_method_setting_q,
                                     loss_action_select_q,
                                     reverse_select_q,
                                     output_polarity_select_q,
                                     function_mode_q});
          ADDR_OFFSET:      prdata_q <= 32'(output_offset_setting_q);
          ADDR_FILTER:      prdata_q <= 32'(output_filter_time_constant_q);
          ADDR_GAIN:        prdata_q <= 32'(output_gain_setting_q);
          ADDR_LOW_LEVEL:   prdata_q <= 32'(low_detection_level_q);
          ADDR_LOW_TIME:    prdata_q <= 32'(low_detection_time_q);
          ADDR_HIGH_LEVEL:  prdata_q <= 32'(high_detection_level_q);
          ADDR_HIGH_TIME:   prdata_q <= 32'(high_detection_time_q);
          ADDR_SLEEP_LEVEL: prdata_q <= 32'(sleep_level_q);
          ADDR_SLEEP_DELAY: prdata_q <= 32'(sleep_delay_q);
          ADDR_STATUS: prdata_q <= 32'({fault_kind_q, alarm_q,
                                       fb_high_flag_q, fb_low_flag_q,
                                       sleep_q});
          ADDR_IRQ_STATUS:  prdata_q <= 32'(irq_status_q);
          ADDR_IRQ_MASK:    prdata_q <= 32'(irq_mask_q);
          ADDR_OUTPUT: prdata_q <= {14'h0, dir_reverse_q, run_enable_q,
                                    freq_cmd_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

endmodule : pid_output_feedback_sleep

// ==== test/drive_sensor_model.sv ====
module drive_sensor_model (
  // Drive stage side
  input  wire logic        pclk,
  input  wire logic        run_enable_q,
  input  wire logic [15:0] fb_target,
  // Sensor side
  output logic      [15:0] feedback_in = 16'h0000,
  output logic             running = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor lags the process by a cycle, as a real transducer would
  always @(posedge pclk) begin
    feedback_in <= fb_target;
    running     <= run_enable_q;
  end
endmodule : drive_sensor_model

// ==== test/pid_post_asserts.sv ====
module pid_post_asserts
  import pid_post_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready_q,
  input wire logic        pslverr_q,
  // Drive side
  input wire logic        run_cmd_in,
  input wire logic        run_enable_q,
  input wire logic [1:0]  stop_method_q,
  input wire logic        fault_q,
  input wire logic        sleep_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control write; effects may land one edge late
  wire ctrl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
  sequence setup_s;
    psel && !penable;
  endsequence
  AST_READY: assert property (setup_s |=> pready_q)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  AST_ERR: assert property (pslverr_q |-> pready_q)
    else $error("slave error without ready");
  AST_CMD: assert property (!run_cmd_in |=> !run_enable_q)
    else $error("runs without run command");
  AST_FAULT_STOP: assert property (fault_q [*2] |-> !run_enable_q)
    else $error("runs while faulted");
  AST_FAULT_HOLD: assert property ($fell(fault_q) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("fault dropped");
  AST_SLEEP_STOP: assert property (sleep_q [*2] |-> !run_enable_q)
    else $error("runs while asleep");
  AST_STOP_SEL: assert property ($changed(stop_method_q) |->
    $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("stop method moved");
endmodule : pid_post_asserts

// ==== test/tb.sv ====
module tb
  import pid_post_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 10;
  localparam int TICK = SC * DWELL_STEPS;
  // Stimulus
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pid_disable_in = 1'h0, run_cmd_in = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic signed [15:0] pid_core_in = 16'sh0000;
  logic [15:0] freq_ref_in = 16'h0064, max_freq_in = 16'h0258;
  logic [15:0] fb_target = 16'h01f4;
  // Observed
  logic [31:0] prdata_q, r;
  logic pready_q, pslverr_q, dir_reverse_q, run_enable_q, fb_low_flag_q;
  logic fb_high_flag_q, alarm_q, fault_q, sleep_q, irq_q, running, err;
  logic [15:0] feedback_in, freq_cmd_q;
  logic [1:0] stop_method_q;
  int errors = 0;
  int samples_checked = 0;
  wire [2:0] fb_view = {fault_q, alarm_q, fb_low_flag_q};
  localparam logic [11:0] RA [11] = '{ADDR_CTRL, ADDR_OFFSET, ADDR_FILTER,
    ADDR_GAIN, ADDR_LOW_LEVEL, ADDR_LOW_TIME, ADDR_HIGH_LEVEL,
    ADDR_HIGH_TIME, ADDR_SLEEP_LEVEL, ADDR_SLEEP_DELAY, ADDR_IRQ_MASK};
  localparam logic [31:0] RV [11] = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h0,
    32'h0a, 32'h64, 32'h0a, 32'h0, 32'h0, 32'h0};
  localparam logic [31:0] CT [5] = '{32'h9, 32'h19, 32'hb, 32'h4, 32'h2};
  localparam logic [31:0] CO [5] = '{32'h0, 32'h300c8, 32'h30064,
    32'h1012c, 32'h100c8};
  localparam logic [31:0] LE [3] = '{32'h1, 32'h3, 32'h4};
  pid_output_feedback_sleep #(.STEP_CYCLES(SC))
    pid_output_feedback_sleep_i (.*);
  drive_sensor_model drive_sensor_model_i (.*);
  always #5 pclk = ~pclk;
  task automatic finish_test;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  // One transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready_q === 1'h1) break;
    end
    if (n == 16) begin
      errors++;
      finish_test();
    end
    r = prdata_q;
    err = pslverr_q;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check("register", r, e);
  endtask : rd
  initial begin
    wt(8);
    presetn <= 1'h1;
    for (int i = 0; i < 11; i++) rd(RA[i], RV[i]);
    apb(1'h0, 12'h040, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(ADDR_CTRL, 32'ha0);
    wr(ADDR_CTRL, 32'he0);
    rd(ADDR_CTRL, 32'ha0); // Loss range kept
    $display("test registers done");
    // Offset, lag filter and gain on the controller output
    wr(ADDR_OFFSET, 32'h64);
    wr(ADDR_GAIN, 32'hc8);
    pid_core_in <= 16'sh00c8;
    wr(ADDR_CTRL, 32'h1);
    wt(4);
    rd(ADDR_OUTPUT, 32'h10258); // Scaled command
    wr(ADDR_FILTER, 32'h64);
    pid_core_in <= 16'sh0000;
    wt(3 * SC);
    check("lag", 32'(freq_cmd_q>16'hc8 && freq_cmd_q<16'h258), 1);
    wr(ADDR_FILTER, 32'h0);
    wt(4);
    rd(ADDR_OUTPUT, 32'h100c8); // Bypass
    wr(ADDR_OFFSET, 32'h0);
    wr(ADDR_GAIN, 32'h64);
    pid_core_in <= 16'sh00c8;
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CTRL, CT[k]);
      wt(4);
      rd(ADDR_OUTPUT, CO[k]); // Sign handling
    end
    $display("test output path done");
    // Low feedback in each loss class, with a dwell restart
    wr(ADDR_LOW_LEVEL, 32'h32);
    wr(ADDR_LOW_TIME, 32'h3);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, 32'h1 | 32'(m << 5));
      fb_target <= 16'h0064;
      wt(2 * TICK - 10);
      fb_target <= 16'h01f4;
      wt(4);
      fb_target <= 16'h0064;
      wt(2 * TICK - 10);
      check("dwell", fb_view, 0);
      wt(TICK + 20);
      check("loss", fb_view, LE[m]);
      check("stopped", 32'(running), 32'(m < 2));
      fb_target <= 16'h01f4;
      wr(ADDR_CTRL, 32'h401);
      wt(4);
      check("cleared", fb_view, 0);
    end
    // Controller disabled by input; interrupt raised, masked, cleared
    pid_disable_in <= 1'h1;
    wr(ADDR_IRQ_STATUS, 32'h1f);
    wr(ADDR_IRQ_MASK, 32'h1);
    for (int m = 1; m < 5; m += 3) begin
      wr(ADDR_CTRL, 32'h1 | 32'(m << 5));
      fb_target <= 16'h0064;
      wt(3 * TICK + 20);
      check("disabled", {alarm_q, irq_q}, m > 3 ? 3 : 0);
    end
    wr(ADDR_IRQ_MASK, 32'h0);
    wt(3);
    check("masked", 32'(irq_q), 32'h0);
    fb_target <= 16'h01f4;
    pid_disable_in <= 1'h0;
    wr(ADDR_IRQ_STATUS, 32'h1f);
    rd(ADDR_IRQ_STATUS, 32'h0);
    // High feedback at default level and time
    wr(ADDR_CTRL, 32'h1);
    fb_target <= 16'h03f2;
    wt(9 * TICK - 10);
    check("high early", 32'(fb_high_flag_q), 0);
    wt(2 * TICK + 20);
    check("high", 32'(fb_high_flag_q), 1);
    fb_target <= 16'h01f4;
    wt(4);
    wr(ADDR_IRQ_STATUS, 32'h1f);
    $display("test feedback done");
    // Sleep with the controller off: 6 Hz against a 10 Hz level
    wr(ADDR_CTRL, 32'h200);
    wr(ADDR_SLEEP_DELAY, 32'h2);
    wr(ADDR_SLEEP_LEVEL, 32'h64);
    wt(TICK - 10);
    check("sleep early", 32'(sleep_q), 0);
    wt(TICK + 40);
    check("asleep", {sleep_q, running, stop_method_q}, 'ha);
    rd(ADDR_STATUS, 32'h1);
    freq_ref_in <= 16'h01f4;
    wt(TICK - 10);
    check("wake early", 32'(sleep_q), 1);
    wt(TICK + 40);
    check("awake", {sleep_q, running, stop_method_q}, 'h6);
    rd(ADDR_IRQ_STATUS, 32'h18);
    // Dropping the run command must stop the drive
    run_cmd_in <= 1'h0;
    wt(3);
    check("run cmd", 32'(running), 32'h0);
    $display("test sleep done");
    finish_test();
  end
endmodule : tb
bind pid_output_feedback_sleep pid_post_asserts chk_i (.*);
